// ---- rtl/edge_detect.v ----
// Edge detector for the chip select samples
`timescale 1ns/1ns
module edge_detect (
   input wire clk_sys,
   input wire rst_b,
   input wire sig,
   output wire rise,
   output wire fall,
   output wire level
);
   reg prev;
   reg cur;
   // Inputs are synchronous; two stages give a stable previous value
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cur <= 1'b1;
         prev <= 1'b1;
      end else begin
         cur <= sig;
         prev <= cur;
      end
   end
   assign rise = cur & ~prev;
   assign fall = ~cur & prev;
   assign level = cur;
endmodule // edge_detect

// ---- rtl/flash_front_map.vh ----
// Constants of the serial flash front end
// Contract
// - Selected only while chip select low
// - Deselect: standby, output line floats
// - Deselected: serial input fully ignored
// - Select fall starts, rise ends operation
// - Busy cycle continues after select rise
// - Sample input on serial clock rise
// - Change output only on clock fall
// - Dual read drives both data lines
// - Modes 0 and 3, same edges
// - Output line carries first dual bit
`ifndef FLASH_FRONT_MAP_VH
`define FLASH_FRONT_MAP_VH
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define DUAL_LAST 3'h3
`define MODE_SINGLE 1'b0
`define MODE_DUAL 1'b1
`define SYNC_RESET 2'h3
`endif

// ---- rtl/flash_serial_front_end.v ----
// Serial front end of a small flash: framing, shift in and shift out
`timescale 1ns/1ns
`include "flash_front_map.vh"
module flash_serial_front_end (
   input wire clk_sys,
   input wire rst_b,
   input wire sel_b,
   input wire sclk,
   input wire dual_data_line_low_in,
   output reg dual_data_line_low_out,
   output wire dual_data_line_low_oe,
   output reg dual_data_line_high_out,
   output wire dual_data_line_high_oe,
   output reg [7:0] rx_byte,
   output reg rx_valid,
   output reg frame_start,
   output reg frame_end,
   input wire [7:0] tx_byte,
   output reg tx_load,
   input wire dual_mode,
   input wire tx_enable,
   input wire busy,
   output wire standby
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ACTIVE = 2'h1;
   localparam ST_FINISH = 2'h2;

   wire sclk_rise;
   wire sclk_fall;
   wire sel_rise;
   wire sel_fall;
   wire sel_level;
   reg sclk_d;
   reg sclk_q;
   reg di_d;
   reg di_q;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] rx_cnt;
   reg [6:0] rx_shift;
   reg [2:0] tx_cnt;
   reg [7:0] tx_shift;
   reg tx_mode;
   reg drive;
   reg [1:0] pipe_fill;
   wire pipe_ok;
   reg byte_dual;
   reg [2:0] next_tx_cnt;

   // Chip select edges
   edge_detect u_sel (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sig(sel_b),
      .rise(sel_rise),
      .fall(sel_fall),
      .level(sel_level)
   );

   // Clock and data delayed together so data aligns with clock edges.
   // The bit used at a rise is the one seen while the clock was still
   // low, one sample older than the clock; the serial clock must stay
   // at each level for three or more system clocks.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_d <= 1'b0;
         sclk_q <= 1'b0;
         di_d <= 1'b0;
         di_q <= 1'b0;
         pipe_fill <= 2'h0;
      end else begin
         sclk_d <= sclk;
         sclk_q <= sclk_d;
         di_d <= dual_data_line_low_in;
         di_q <= di_d;
         pipe_fill <= {pipe_fill[0], 1'b1};
      end
   end

   // The delay flops reset low whatever the clock's idle level, so in
   // mode 3 the first samples would look like a rise; edges count only
   // once both flops hold real pin samples
   assign pipe_ok = (pipe_fill == `SYNC_RESET);

   // Edge polarity alone is used, so idle level (mode 0 or 3) is moot
   assign sclk_rise = sclk_d & ~sclk_q & pipe_ok;
   assign sclk_fall = ~sclk_d & sclk_q & pipe_ok;

   // Framing state machine
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (sel_fall) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (sel_rise) begin
               next_state = busy ? ST_FINISH : ST_IDLE;
            end
         end
         ST_FINISH: begin
            // Standby waits for the self-timed cycle to finish
            // A select fall in this tail is not taken as a new operation
            if (!busy) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Standby only once deselected and no cycle runs
   // Combinational, so it drops in the very cycle busy rises
   assign standby = (state == ST_IDLE) & sel_level & ~busy;

   // Pulses marking operation boundaries
   // Registered, so each pulse lasts exactly one system clock
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         frame_start <= 1'b0;
         frame_end <= 1'b0;
      end else begin
         frame_start <= (state == ST_IDLE) & sel_fall;
         frame_end <= (state == ST_ACTIVE) & sel_rise;
      end
   end

   // Receive shifter: only while selected, MSB first on clock rise
   // It pauses while we drive, since in dual mode the input pin is ours
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt <= 3'h0;
         rx_shift <= 7'h00;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (state != ST_ACTIVE || sel_level) begin
            rx_cnt <= 3'h0;
         end else if (sclk_rise && !drive) begin
            rx_shift <= {rx_shift[5:0], di_q};
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == `BIT_LAST) begin
               rx_byte <= {rx_shift, di_q};
               rx_valid <= 1'b1;
            end
         end
      end
   end

   // Bit count of the byte being shifted out. A byte's mode is fixed at
   // its first fall, so a change of dual_mode takes effect only at the
   // next byte boundary; dual bytes wrap after four falls, single after 8
   always @* begin
      byte_dual = (tx_cnt == 3'h0) ? dual_mode : tx_mode;
      if (byte_dual == `MODE_DUAL && tx_cnt == `DUAL_LAST) begin
         next_tx_cnt = 3'h0;
      end else begin
         next_tx_cnt = tx_cnt + 3'h1;
      end
   end

   // Transmit shifter: a fresh byte is loaded at each byte boundary;
   // the user must present tx_byte before each boundary; tx_load pulses the cycle after it is taken
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_cnt <= 3'h0;
         tx_shift <= 8'h00;
         tx_mode <= `MODE_SINGLE;
         drive <= 1'b0;
         tx_load <= 1'b0;
         dual_data_line_low_out <= 1'b0;
         dual_data_line_high_out <= 1'b0;
      end else begin
         tx_load <= 1'b0;
         if (state != ST_ACTIVE || sel_level || !tx_enable) begin
            drive <= 1'b0;
            tx_cnt <= 3'h0;
            tx_mode <= dual_mode;
         end else if (sclk_fall) begin
            drive <= 1'b1;
            if (tx_cnt == 3'h0) begin
               tx_mode <= dual_mode;
               tx_load <= 1'b1;
               if (dual_mode) begin
                  dual_data_line_high_out <= tx_byte[7];
                  dual_data_line_low_out <= tx_byte[6];
                  tx_shift <= {tx_byte[5:0], 2'h0};
               end else begin
                  dual_data_line_high_out <= tx_byte[7];
                  tx_shift <= {tx_byte[6:0], 1'b0};
               end
            end else if (tx_mode == `MODE_DUAL) begin
               dual_data_line_high_out <= tx_shift[7];
               dual_data_line_low_out <= tx_shift[6];
               tx_shift <= {tx_shift[5:0], 2'h0};
            end else begin
               dual_data_line_high_out <= tx_shift[7];
               tx_shift <= {tx_shift[6:0], 1'b0};
            end
            tx_cnt <= next_tx_cnt;
         end
      end
   end

   // Output enables: high-impedance whenever deselected
   // The low line is ours only in dual mode; otherwise it stays an input
   assign dual_data_line_high_oe = drive & ~sel_level;
   assign dual_data_line_low_oe = drive & ~sel_level & tx_mode;
endmodule // flash_serial_front_end

// ---- tb/front_end_chk.sv ----
// Checker for the serial front end ports
`timescale 1ns/1ns
module front_end_chk (
   input wire clk_sys,
   input wire rst_b,
   input wire sel_b,
   input wire sclk,
   input wire dual_mode,
   input wire busy,
   input wire standby,
   input wire dual_data_line_low_oe,
   input wire dual_data_line_high_oe,
   input wire dual_data_line_high_out,
   input wire rx_valid,
   input wire frame_start,
   input wire frame_end
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   chk_sel_standby: assert property ((!sel_b) [*4] |-> !standby)
      else $error("standby while selected");
   chk_desel_float: assert property (
      sel_b [*4] |-> !dual_data_line_high_oe)
      else $error("output driven while deselected");
   chk_desel_rx: assert property (sel_b [*4] |-> !rx_valid)
      else $error("byte taken while deselected");
   chk_end_pulse: assert property (
      $rose(sel_b) |-> ##[1:4] frame_end)
      else $error("no end pulse after select rise");
   chk_start_once: assert property (frame_start |=> !frame_start)
      else $error("start pulse too long");
   chk_busy_hold: assert property (busy [*2] |-> !standby)
      else $error("standby during busy cycle");
   chk_standby_back: assert property (
      (sel_b && !busy) [*3] |-> standby)
      else $error("no standby after busy cycle ended");
   chk_rx_once: assert property (rx_valid |=> !rx_valid)
      else $error("rx pulse too long");
   chk_out_fall: assert property (
      !$stable(dual_data_line_high_out) && dual_data_line_high_oe &&
      !sel_b |-> !sclk)
      else $error("output moved outside clock low");
   chk_dual_both: assert property (
      dual_data_line_low_oe |-> dual_data_line_high_oe && dual_mode)
      else $error("low line driven alone");
   cov_start: cover property (frame_start);
   cov_rx: cover property (rx_valid);
   cov_dual: cover property (dual_data_line_low_oe);
   cov_busy_end: cover property (busy && $rose(sel_b));
endmodule // front_end_chk
bind flash_serial_front_end front_end_chk u_chk (.*);

// ---- tb/spi_host_model.sv ----
// Host model: drives select, serial clock and the input line
`timescale 1ns/1ns
module spi_host_model (
   input wire clk_sys,
   input wire lo_in,
   input wire hi_in,
   output reg sel_b = 1'b1,
   output reg sclk = 1'b0,
   output reg si = 1'b0
);
   reg idle = 1'b0; // Clock idle level, mode 0 or 3
   task wt(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Falling edge starts an operation
   task open_f();
      // Clock settles at its idle level before select falls
      sclk <= idle;
      wt(2);
      sel_b <= 1'b0;
      wt(6);
   endtask
   task close_f();
      sclk <= idle;
      wt(6);
      sel_b <= 1'b1;
      wt(8);
   endtask
   // One byte MSB first; dual takes two bits per fall
   task xb(input [7:0] d, input dual, output [7:0] q);
      integer i;
      for (i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
         sclk <= 1'b0;
         // Released line toggles so a stale value never passes
         si <= dual ? ~si : d[i];
         wt(6);
         q[i] = hi_in;
         if (dual) q[i-1] = lo_in;
         sclk <= 1'b1;
         wt(6);
      end
   endtask
endmodule // spi_host_model

// ---- tb/tb.sv ----
// Testbench for the serial front end
`timescale 1ns/1ns
module tb;
   reg clk_sys = 1'b0, rst_b = 1'b0, dual_mode = 1'b0;
   reg tx_enable = 1'b0, busy = 1'b0;
   reg [7:0] tx_byte = 8'h00, q;
   wire sel_b, sclk, si, lo_out, lo_oe, hi_out, hi_oe, rx_valid, standby;
   wire tx_load;
   wire [7:0] rx_byte;
   wire lo_line = lo_oe ? lo_out : si;
   // Released output shows the inverse, so an undriven bit never passes
   wire hi_line = hi_oe ? hi_out : ~hi_out;
   integer mismatches = 0, n_compared = 0, nrx = 0, ntl = 0, n0;
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (rx_valid === 1'b1) nrx <= nrx + 1;
   always @(posedge clk_sys) if (tx_load === 1'b1) ntl <= ntl + 1;
   spi_host_model host (.clk_sys(clk_sys), .lo_in(lo_line),
      .hi_in(hi_line), .sel_b(sel_b), .sclk(sclk), .si(si));
   flash_serial_front_end dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .sel_b(sel_b), .sclk(sclk), .dual_data_line_low_in(lo_line),
      .dual_data_line_low_out(lo_out), .dual_data_line_low_oe(lo_oe),
      .dual_data_line_high_out(hi_out), .dual_data_line_high_oe(hi_oe),
      .rx_byte(rx_byte), .rx_valid(rx_valid), .frame_start(),
      .frame_end(), .tx_byte(tx_byte), .tx_load(tx_load),
      .dual_mode(dual_mode),
      .tx_enable(tx_enable), .busy(busy), .standby(standby));
   task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Write one byte in the given clock mode
   task t_write(input m, input [7:0] d);
      host.idle = m;
      n0 = nrx;
      host.open_f();
      host.xb(d, 1'b0, q);
      host.close_f();
      chk("rx", rx_byte, d);
      chk("nrx", nrx - n0, 8'h01);
   endtask
   // Read one byte, single or dual, in mode 3
   task t_read(input dm, input [7:0] d);
      host.idle = 1'b1;
      dual_mode <= dm;
      tx_byte <= d;
      tx_enable <= 1'b1;
      n0 = ntl;
      host.open_f();
      host.xb(8'h00, dm, q);
      host.close_f();
      chk("rd", q, d);
      chk("tl", ntl - n0, 8'h01);
      tx_enable <= 1'b0;
      dual_mode <= 1'b0;
      host.wt(1);
   endtask
   // Clock and data while deselected must do nothing
   task t_desel();
      n0 = nrx;
      host.xb(8'hff, 1'b0, q);
      chk("ign", nrx - n0, 8'h00);
      chk("oe", {7'h0, hi_oe}, 8'h00);
      chk("stby", {7'h0, standby}, 8'h01);
   endtask
   // Busy cycle keeps the device out of standby
   task t_busy();
      busy <= 1'b1;
      host.open_f();
      host.close_f();
      chk("busy", {7'h0, standby}, 8'h00);
      busy <= 1'b0;
      host.wt(6);
      chk("idle", {7'h0, standby}, 8'h01);
   endtask
   initial begin
      host.wt(2);
      rst_b <= 1'b1;
      host.wt(4);
      t_write(1'b0, 8'ha5);
      t_write(1'b1, 8'h3c);
      t_read(1'b0, 8'h96);
      t_read(1'b1, 8'hc9);
      t_desel();
      t_busy();
      summarize();
   end
   // Whole run takes about 560 cycles; this limit is far beyond it
   initial begin
      #200000;
      mismatches = mismatches + 1;
      summarize();
   end
endmodule // tb
